// ===== dv/eic_ctrl_tb.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module eic_ctrl_tb;
   import eic_pkg::*;
   typedef struct packed {logic m16; logic [7:0] a; eic_byte_t w; eic_byte_t e;} eic_row_t;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic bus16_mode_i = 1'b0;
   logic special = 1'b0;
   logic sel, rd, wr, irq_arr, irq_pin, irq_oe;
   logic [7:0] addr, src;
   eic_byte_t wdata, rdata;
   int failures = 0;
   int check_count = 0;
   eic_row_t rows [7] = '{'{1'b0, 8'hd3, 8'ha5, 8'ha5}, '{1'b0, 8'hd2, 8'h3c, 8'h3c},
      '{1'b1, 8'hd2, 8'h5a, 8'h5a}, '{1'b1, 8'hd3, 8'hc3, 8'hc3}, '{1'b0, 8'hd5, 8'hff, 8'h00},
      '{1'b1, 8'hd4, 8'hff, 8'h00}, '{1'b0, 8'hd1, 8'hff, 8'h00}};
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   eic_host_model eic_host_model_i (.clk_i(clk_i), .rdata_i(rdata), .sel_o(sel), .rd_o(rd), .wr_o(wr),
      .addr_o(addr), .wdata_o(wdata), .src_o(src));
   eic_ctrl eic_ctrl_i (.clk_i(clk_i), .reset_i(reset_i), .terminal_count_i(src[3:0]),
      .product_term_irq_4_i(src[4]), .product_term_irq_5_i(src[5]), .macrocell_irq_6_i(src[6]),
      .macrocell_irq_7_i(src[7]), .io_window_select_i(sel), .bus16_mode_i(bus16_mode_i), .addr_i(addr),
      .rd_i(rd), .wr_i(wr), .wdata_i(wdata), .rdata_o(rdata), .port_e_bit_2_special_i(special),
      .global_irq_to_array_o(irq_arr), .global_irq_pin_o(irq_pin), .global_irq_pin_oe_o(irq_oe));
   task automatic check(input eic_byte_t seen, input eic_byte_t exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr_reg(input logic [7:0] a, input eic_byte_t d);
      eic_byte_t q;
      eic_host_model_i.access(1'b1, a, d, q);
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input eic_byte_t e);
      eic_byte_t q;
      eic_host_model_i.access(1'b0, a, 8'h00, q);
      check(q, e);
   endtask : rd_chk
   task automatic settle();
      repeat (2) @(posedge clk_i);
      #1;
   endtask : settle
   task automatic summarize();
      $display("checks=%0d failures=%0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : summarize
   initial begin
      #200000;
      failures++;
      summarize();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      foreach (rows[k]) begin
         bus16_mode_i <= rows[k].m16;
         wr_reg(rows[k].a, rows[k].w);
         rd_chk(rows[k].a, rows[k].e);
      end
      bus16_mode_i <= 1'b0;
      rd_chk(8'hd3, 8'h5a);
      rd_chk(8'hd2, 8'hc3);
      $display("register map test done");
      wr_reg(8'hd2, 8'h00);
      wr_reg(8'hd3, 8'hff);
      special <= 1'b1;
      eic_host_model_i.pulse(8'hc4);
      settle();
      check({7'h00, irq_arr}, 8'h01);
      check({6'h00, irq_pin, irq_oe}, 8'h03);
      rd_chk(8'hd1, 8'hc4);
      rd_chk(8'hd0, 8'h07);
      rd_chk(8'hd0, 8'h06);
      rd_chk(8'hd1, 8'h04);
      rd_chk(8'hd0, 8'h02);
      rd_chk(8'hd0, 8'h00);
      rd_chk(8'hd1, 8'h00);
      #1;
      check({7'h00, irq_arr}, 8'h00);
      $display("priority test done");
      wr_reg(8'hd2, 8'h10);
      eic_host_model_i.hold(8'h10);
      eic_host_model_i.pulse(8'h01);
      settle();
      rd_chk(8'hd1, 8'h11);
      rd_chk(8'hd4, 8'h00);
      rd_chk(8'hd1, 8'h10);
      eic_host_model_i.hold(8'h00);
      wr_reg(8'hd2, 8'h00);
      bus16_mode_i <= 1'b1;
      rd_chk(8'hd0, 8'h10);
      rd_chk(8'hd5, 8'h00);
      rd_chk(8'hd0, 8'h00);
      bus16_mode_i <= 1'b0;
      rd_chk(8'hd4, 8'h00);
      $display("level and clear test done");
      wr_reg(8'hd3, 8'h01);
      eic_host_model_i.pulse(8'h80);
      settle();
      rd_chk(8'hd1, 8'h00);
      check({7'h00, irq_arr}, 8'h00);
      eic_host_model_i.pulse(8'h01);
      settle();
      check({7'h00, irq_arr}, 8'h01);
      $display("mask test done");
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      rd_chk(8'hd3, 8'h00);
      rd_chk(8'hd2, 8'h00);
      rd_chk(8'hd1, 8'h00);
      check({7'h00, irq_arr}, 8'h00);
      $display("reset test done");
      summarize();
   end
endmodule : eic_ctrl_tb

// ===== dv/eic_host_model.sv
// host bus and event-source model facing the interrupt controller
`timescale 1ns/1ps
module eic_host_model (
   input wire logic clk_i,
   input wire eic_pkg::eic_byte_t rdata_i,
   output logic sel_o,
   output logic rd_o,
   output logic wr_o,
   output logic [7:0] addr_o,
   output eic_pkg::eic_byte_t wdata_o,
   output logic [7:0] src_o
);
   import eic_pkg::*;
   initial begin
      {sel_o, rd_o, wr_o} = 3'h0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
      src_o = 8'h00;
   end
   // one access per call; released lines show the inverse so stale values never pass
   task automatic access(input logic wr, input logic [7:0] a, input eic_byte_t d, output eic_byte_t q);
      @(posedge clk_i);
      {sel_o, rd_o, wr_o} <= {1'b1, ~wr, wr};
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      {sel_o, rd_o, wr_o} <= 3'h0;
      addr_o <= ~a;
      wdata_o <= ~d;
      #1;
      q = rdata_i;
   endtask : access
   // external events reach the controller as timer terminal counts (bits 3..0) and logic-array outputs (bits 7..4)
   task automatic pulse(input logic [7:0] m);
      @(posedge clk_i);
      src_o <= src_o | m;
      @(posedge clk_i);
      src_o <= src_o & ~m;
   endtask : pulse
   task automatic hold(input logic [7:0] v);
      @(posedge clk_i);
      src_o <= v;
   endtask : hold
endmodule : eic_host_model

// ===== logic/eic_cfg.svh
// offsets, reset values, input count and vector width of the interrupt controller
`ifndef EIC_CFG_SVH
`define EIC_CFG_SVH
`define EIC_NUM_IRQ 8
`define EIC_VEC_W 3
`define EIC_OFS8_VECTOR 8'hd0
`define EIC_OFS8_PENDING 8'hd1
`define EIC_OFS8_TRIGGER 8'hd2
`define EIC_OFS8_ENABLE 8'hd3
`define EIC_OFS8_CLEAR 8'hd4
`define EIC_OFS16_PENDING 8'hd0
`define EIC_OFS16_VECTOR 8'hd1
`define EIC_OFS16_ENABLE 8'hd2
`define EIC_OFS16_TRIGGER 8'hd3
`define EIC_OFS16_CLEAR 8'hd5
`define EIC_RST_ENABLE 8'h00
`define EIC_RST_TRIGGER 8'h00
`define EIC_RST_PENDING 8'h00
`endif

// ===== logic/eic_ctrl.sv
// eight-input interrupt controller with host register window
`timescale 1ns/1ps
`include "eic_cfg.svh"
// Notes on behaviour
// [R01] enable bit i lets input i latch
// [R02] reset clears all enable bits
// [R03] trigger bit 1 level, 0 rising edge
// [R04] reset clears all trigger bits
// [R05] clear register read drops edge requests
// [R06] pending bit i set when request waits
// [R07] pending latch readable at any time
// [R08] vector register low bits give top request
// [R09] vector bits 7..3 read zero
// [R10] vector read clears the returned request
// [R11] inputs 0..3 from timer terminal counts
// [R12] inputs 4,5 from array product terms
// [R13] inputs 6,7 from array macrocells
// [R14] global interrupt on any unmasked request
// [R15] global to array, optionally port pin
// [R16] external events go through logic array
// [R17] offsets for 8-bit and 16-bit hosts
// [R18] decode within 256-byte io window
// [R19] input 7 highest, input 0 lowest
// [R20] global held while enabled pending exists
// [R21] empty vector reads zero, changes nothing
module eic_ctrl (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [3:0] terminal_count_i,
   input wire logic product_term_irq_4_i,
   input wire logic product_term_irq_5_i,
   input wire logic macrocell_irq_6_i,
   input wire logic macrocell_irq_7_i,
   input wire logic io_window_select_i,
   input wire logic bus16_mode_i,
   input wire logic [7:0] addr_i,
   input wire logic rd_i,
   input wire logic wr_i,
   input wire eic_pkg::eic_byte_t wdata_i,
   output eic_pkg::eic_byte_t rdata_o,
   input wire logic port_e_bit_2_special_i,
   output logic global_irq_to_array_o,
   output logic global_irq_pin_o,
   output logic global_irq_pin_oe_o
);
   import eic_pkg::*;

   eic_byte_t enable_bits;
   eic_byte_t trigger_select;
   eic_byte_t pending_latch;
   eic_byte_t prev_req;
   eic_byte_t rdata;
   eic_byte_t next_enable_bits;
   eic_byte_t next_trigger_select;
   eic_byte_t next_pending_latch;
   eic_byte_t next_rdata;
   eic_byte_t req;
   eic_byte_t rise;
   eic_byte_t set_mask;
   eic_byte_t clr_mask;
   eic_reg_t sel;
   logic [2:0] top_index;
   logic top_any;
   logic global_irq;

   // the controller has no pins of its own; all sources are internal
   assign req = {macrocell_irq_7_i, macrocell_irq_6_i, // see [R13] [R16]
                 product_term_irq_5_i, product_term_irq_4_i, // see [R12]
                 terminal_count_i}; // see [R11]
   assign rise = req & ~prev_req;

   // register decode: the window select marks the 256-byte io space
   always_comb begin
      sel = EIC_REG_NONE;
      if (io_window_select_i) begin // see [R18]
         if (!bus16_mode_i) begin // see [R17]
            case (addr_i)
               `EIC_OFS8_VECTOR: sel = EIC_REG_VECTOR;
               `EIC_OFS8_PENDING: sel = EIC_REG_PENDING;
               `EIC_OFS8_TRIGGER: sel = EIC_REG_TRIGGER;
               `EIC_OFS8_ENABLE: sel = EIC_REG_ENABLE;
               `EIC_OFS8_CLEAR: sel = EIC_REG_CLEAR;
               default: sel = EIC_REG_NONE;
            endcase
         end else begin
            case (addr_i)
               `EIC_OFS16_VECTOR: sel = EIC_REG_VECTOR;
               `EIC_OFS16_PENDING: sel = EIC_REG_PENDING;
               `EIC_OFS16_TRIGGER: sel = EIC_REG_TRIGGER;
               `EIC_OFS16_ENABLE: sel = EIC_REG_ENABLE;
               `EIC_OFS16_CLEAR: sel = EIC_REG_CLEAR;
               default: sel = EIC_REG_NONE;
            endcase
         end
      end
   end

   // the vector is taken from enabled pending bits, so a masked stale bit is never reported
   eic_prio_enc u_prio (
      .req_i(pending_latch & enable_bits),
      .index_o(top_index),
      .any_o(top_any)
   );

   always_comb begin
      next_enable_bits = enable_bits;
      next_trigger_select = trigger_select;
      if (wr_i && sel == EIC_REG_ENABLE) begin
         next_enable_bits = wdata_i; // see [R01]
      end
      if (wr_i && sel == EIC_REG_TRIGGER) begin
         next_trigger_select = wdata_i; // see [R03]
      end
   end

   always_comb begin
      // level inputs latch while high, edge inputs on a rising edge only
      set_mask = enable_bits & ((trigger_select & req) | (~trigger_select & rise)); // see [R01] [R03] [R06]
      clr_mask = 8'h00;
      if (rd_i && sel == EIC_REG_CLEAR) begin
         clr_mask = ~trigger_select; // see [R05]
      end
      if (rd_i && sel == EIC_REG_VECTOR && top_any) begin // see [R21]
         clr_mask[top_index] = 1'b1; // see [R10]
      end
      // a new request in the clearing cycle survives: set wins
      next_pending_latch = (pending_latch & ~clr_mask) | set_mask; // see [R06]
   end

   always_comb begin
      next_rdata = 8'h00;
      if (rd_i) begin
         case (sel)
            EIC_REG_VECTOR: next_rdata = {5'h00, top_index}; // see [R08] [R09] [R21]
            EIC_REG_PENDING: next_rdata = pending_latch; // see [R07]
            EIC_REG_TRIGGER: next_rdata = trigger_select;
            EIC_REG_ENABLE: next_rdata = enable_bits;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         enable_bits <= `EIC_RST_ENABLE; // see [R02]
         trigger_select <= `EIC_RST_TRIGGER; // see [R04]
         pending_latch <= `EIC_RST_PENDING;
         prev_req <= 8'h00;
         rdata <= 8'h00;
      end else begin
         enable_bits <= next_enable_bits;
         trigger_select <= next_trigger_select;
         pending_latch <= next_pending_latch;
         prev_req <= req;
         rdata <= next_rdata;
      end
   end

   assign global_irq = |(pending_latch & enable_bits); // see [R14] [R20]
   assign rdata_o = rdata;
   assign global_irq_to_array_o = global_irq; // see [R15]
   assign global_irq_pin_o = global_irq & port_e_bit_2_special_i; // see [R15]
   assign global_irq_pin_oe_o = port_e_bit_2_special_i;

   property p_reset_clears;
      @(posedge clk_i) reset_i |=> (enable_bits == 8'h00 && trigger_select == 8'h00);
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("config not cleared by reset"); // see [R02] [R04]

   property p_masked_no_latch;
      @(posedge clk_i) disable iff (reset_i)
         (!enable_bits[7] && !pending_latch[7]) |=> !pending_latch[7];
   endproperty
   a_masked_no_latch: assert property (p_masked_no_latch) else $error("masked input latched"); // see [R01]

   property p_edge_latch;
      @(posedge clk_i) disable iff (reset_i)
         (enable_bits[2] && !trigger_select[2] && req[2] && !prev_req[2]) |=> pending_latch[2];
   endproperty
   a_edge_latch: assert property (p_edge_latch) else $error("rising edge not latched"); // see [R03] [R06]

   property p_level_survives_clear;
      @(posedge clk_i) disable iff (reset_i)
         (rd_i && sel == EIC_REG_CLEAR && trigger_select[4] && enable_bits[4] && req[4]) |=> pending_latch[4];
   endproperty
   a_level_survives_clear: assert property (p_level_survives_clear) else $error("level request lost"); // see [R05]

   property p_clear_edge;
      @(posedge clk_i) disable iff (reset_i)
         (rd_i && sel == EIC_REG_CLEAR && !trigger_select[0] && !rise[0]) |=> !pending_latch[0];
   endproperty
   a_clear_edge: assert property (p_clear_edge) else $error("edge request not cleared"); // see [R05]

   property p_vector_read;
      @(posedge clk_i) disable iff (reset_i)
         (rd_i && sel == EIC_REG_VECTOR) |=> (rdata_o == {5'h00, $past(top_index)});
   endproperty
   a_vector_read: assert property (p_vector_read) else $error("vector read wrong"); // see [R08] [R09]

   property p_vector_top7;
      @(posedge clk_i) disable iff (reset_i)
         (pending_latch[7] && enable_bits[7]) |-> top_index == 3'h7;
   endproperty
   a_vector_top7: assert property (p_vector_top7) else $error("input 7 not top"); // see [R19]

   property p_vector_clears;
      @(posedge clk_i) disable iff (reset_i)
         (rd_i && sel == EIC_REG_VECTOR && top_any && !set_mask[top_index]) |=> !pending_latch[$past(top_index)];
   endproperty
   a_vector_clears: assert property (p_vector_clears) else $error("vector read did not clear"); // see [R10]

   property p_empty_read;
      @(posedge clk_i) disable iff (reset_i)
         (rd_i && sel == EIC_REG_VECTOR && !top_any) |=>
            (rdata_o == 8'h00 && ($past(pending_latch) & ~pending_latch) == 8'h00);
   endproperty
   a_empty_read: assert property (p_empty_read) else $error("empty vector read wrong"); // see [R21]

   property p_global;
      @(posedge clk_i) disable iff (reset_i)
         (|(enable_bits & rise) && !(wr_i && sel == EIC_REG_ENABLE)) |=> global_irq_to_array_o;
   endproperty
   a_global: assert property (p_global) else $error("global interrupt wrong"); // see [R14] [R20]

   property p_pin;
      @(posedge clk_i) disable iff (reset_i)
         (!port_e_bit_2_special_i) |-> (!global_irq_pin_oe_o && !global_irq_pin_o);
   endproperty
   a_pin: assert property (p_pin) else $error("pin driven while unselected"); // see [R15]

   property p_pin_follows;
      @(posedge clk_i) disable iff (reset_i)
         port_e_bit_2_special_i |-> (global_irq_pin_oe_o && global_irq_pin_o == global_irq_to_array_o);
   endproperty
   a_pin_follows: assert property (p_pin_follows) else $error("pin does not follow global"); // see [R15]

   property p_reset_idle;
      @(posedge clk_i) reset_i |=> (pending_latch == 8'h00 && rdata_o == 8'h00 && !global_irq_to_array_o);
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("state not idle after reset"); // see [R02] [R04]

   // write checks decode the raw offset, so a slip in the decoder itself is caught
   property p_enable_write8;
      @(posedge clk_i) disable iff (reset_i)
         (wr_i && io_window_select_i && !bus16_mode_i && addr_i == `EIC_OFS8_ENABLE) |=> enable_bits == $past(wdata_i);
   endproperty
   a_enable_write8: assert property (p_enable_write8) else $error("8-bit enable write lost"); // see [R01] [R17]

   property p_enable_write16;
      @(posedge clk_i) disable iff (reset_i)
         (wr_i && io_window_select_i && bus16_mode_i && addr_i == `EIC_OFS16_ENABLE) |=> enable_bits == $past(wdata_i);
   endproperty
   a_enable_write16: assert property (p_enable_write16) else $error("16-bit enable write lost"); // see [R17]

   property p_trigger_write8;
      @(posedge clk_i) disable iff (reset_i)
         (wr_i && io_window_select_i && !bus16_mode_i && addr_i == `EIC_OFS8_TRIGGER) |=>
            trigger_select == $past(wdata_i);
   endproperty
   a_trigger_write8: assert property (p_trigger_write8) else $error("8-bit trigger write lost"); // see [R03] [R17]

   property p_trigger_write16;
      @(posedge clk_i) disable iff (reset_i)
         (wr_i && io_window_select_i && bus16_mode_i && addr_i == `EIC_OFS16_TRIGGER) |=>
            trigger_select == $past(wdata_i);
   endproperty
   a_trigger_write16: assert property (p_trigger_write16) else $error("16-bit trigger write lost"); // see [R17]

   property p_outside_window;
      @(posedge clk_i) disable iff (reset_i)
         !io_window_select_i |=> ($stable(enable_bits) && $stable(trigger_select));
   endproperty
   a_outside_window: assert property (p_outside_window) else $error("config changed outside window"); // see [R18]

   property p_level_latch;
      @(posedge clk_i) disable iff (reset_i)
         (enable_bits[4] && trigger_select[4] && req[4]) |=> pending_latch[4];
   endproperty
   a_level_latch: assert property (p_level_latch) else $error("level request not latched"); // see [R03]

   property p_pending_read;
      @(posedge clk_i) disable iff (reset_i)
         (rd_i && sel == EIC_REG_PENDING) |=> rdata_o == $past(pending_latch);
   endproperty
   a_pending_read: assert property (p_pending_read) else $error("pending read wrong"); // see [R07]

   property p_reserved_zero;
      @(posedge clk_i) disable iff (reset_i)
         (rd_i && sel == EIC_REG_VECTOR) |=> rdata_o[7:3] == 5'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved vector bits set"); // see [R09]

   property p_clear_reads_zero;
      @(posedge clk_i) disable iff (reset_i)
         (rd_i && sel == EIC_REG_CLEAR) |=> rdata_o == 8'h00;
   endproperty
   a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear register read not zero"); // see [R05]

   // only a clearing read, an enable write or reset may drop the global line
   property p_global_held;
      @(posedge clk_i) disable iff (reset_i)
         (global_irq_to_array_o && !(rd_i && (sel == EIC_REG_VECTOR || sel == EIC_REG_CLEAR))
            && !(wr_i && sel == EIC_REG_ENABLE)) |=> global_irq_to_array_o;
   endproperty
   a_global_held: assert property (p_global_held) else $error("global interrupt dropped"); // see [R20]

   c_edge_irq: cover property (@(posedge clk_i) disable iff (reset_i) rise[0] && enable_bits[0] ##1 global_irq);
   c_vector_read: cover property (@(posedge clk_i) disable iff (reset_i) rd_i && sel == EIC_REG_VECTOR && top_any);
   c_clear_read: cover property (@(posedge clk_i) disable iff (reset_i) rd_i && sel == EIC_REG_CLEAR && |pending_latch);
   c_bus16: cover property (@(posedge clk_i) disable iff (reset_i) wr_i && bus16_mode_i && sel == EIC_REG_ENABLE);
endmodule : eic_ctrl

// ===== logic/eic_pkg.sv
// types shared by the interrupt controller files
package eic_pkg;
   typedef logic [7:0] eic_byte_t;
   typedef enum logic [2:0] {
      EIC_REG_NONE = 3'b000,
      EIC_REG_VECTOR = 3'b001,
      EIC_REG_PENDING = 3'b010,
      EIC_REG_TRIGGER = 3'b011,
      EIC_REG_ENABLE = 3'b100,
      EIC_REG_CLEAR = 3'b101
   } eic_reg_t;
endpackage : eic_pkg

// ===== logic/eic_prio_enc.sv
// fixed-priority encoder, highest index wins
`timescale 1ns/1ps
module eic_prio_enc (
   input wire logic [7:0] req_i,
   output logic [2:0] index_o,
   output logic any_o
);
   always_comb begin
      index_o = 3'h0;
      any_o = |req_i;
      for (int i = 0; i < 8; i++) begin
         if (req_i[i]) begin
            index_o = 3'(i); // see [R19]
         end
      end
   end
endmodule : eic_prio_enc
